// ===== rtl/wwdt_pkg.sv
/*
  Shared constants of the window watchdog: register map, field positions,
  reset values and prescaler ratios.
  Assumes a word-wide register port with one-cycle strobes.
*/
package wwdt_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RELOAD = 8'h04;
  localparam logic [7:0] ADDR_WINDOW = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  // ==========================================================
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLKSEL_BIT = 1;
  localparam int CTRL_DIVSEL_BIT = 2;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_WIN_BIT = 1;
  localparam int EVT_W = 2;
  // ==========================================================
  // prescaler ratios
  localparam int DIV_LO = 256;
  localparam int DIV_HI = 16384;
  localparam int DIV_W = 14;
  // ==========================================================
  // default interval: 0.13 s with the wake-up clock at 500 kHz
  localparam int TIMEOUT_US = 130000;
  localparam int WAKEUP_KHZ = 500;
  localparam int DEF_TICKS = (TIMEOUT_US * WAKEUP_KHZ / 1000) / DIV_LO;
  localparam logic [15:0] RELOAD_RST = 16'((32'h0001_0000) - DEF_TICKS);
  localparam logic [15:0] WINDOW_RST = 16'h0000;
  localparam logic CLKSEL_RST = 1'b1;
  localparam logic DIVSEL_RST = 1'b0;
  localparam logic [EVT_W-1:0] MASK_RST = 2'h0;
endpackage

// ===== rtl/wwdt_edge_sync.sv
/*
  Two-stage synchroniser with rising-edge detector for the wake-up clock.
  Assumes the wake-up clock is well below half the system clock.
*/
`timescale 1ns/1ps
module wwdt_edge_sync (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic async_in, // slow clock to sample
  output logic rise // one-cycle pulse per rising edge
);
  logic meta;
  logic sync;
  logic last;
  logic next_rise;

  // ==========================================================
  // sampling stages
  // first stage feeds only the second stage
  always_comb begin
    next_rise = sync & ~last;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
      rise <= 1'b0;
    end else begin
      meta <= async_in;
      sync <= meta;
      last <= sync;
      rise <= next_rise;
    end
  end
endmodule

// ===== rtl/wwdt_prescaler.sv
/*
  Prescaler of the watchdog: counts source pulses, ticks once per ratio.
  Assumes src_pulse is one system cycle wide per source clock period.
*/
`timescale 1ns/1ps
module wwdt_prescaler #(
  parameter int DIV_A = wwdt_pkg::DIV_LO,
  parameter int DIV_B = wwdt_pkg::DIV_HI
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic clear, // restart the division
  input wire logic src_pulse, // source clock pulse
  input wire logic div_sel, // 0: DIV_A, 1: DIV_B
  output logic tick // one-cycle counter advance
);
  initial begin
    if (DIV_A < 2 || DIV_B < 2 || DIV_A > (1 << wwdt_pkg::DIV_W)
        || DIV_B > (1 << wwdt_pkg::DIV_W)) begin
      $error("wwdt_prescaler: ratio out of range");
    end
  end

  localparam logic [wwdt_pkg::DIV_W-1:0] LAST_A = wwdt_pkg::DIV_W'(DIV_A - 1);
  localparam logic [wwdt_pkg::DIV_W-1:0] LAST_B = wwdt_pkg::DIV_W'(DIV_B - 1);

  logic [wwdt_pkg::DIV_W-1:0] cnt;
  logic [wwdt_pkg::DIV_W-1:0] next_cnt;
  logic next_tick;
  logic at_last;

  // ==========================================================
  // division
  always_comb begin
    at_last = (cnt >= (div_sel ? LAST_B : LAST_A));
    next_cnt = cnt;
    next_tick = 1'b0;
    if (clear) begin
      next_cnt = '0;
    end else if (src_pulse) begin
      if (at_last) begin
        next_cnt = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// ===== rtl/wwdt_top.sv
/*
  Window watchdog timer: 16-bit up-counter, prescaler, window check,
  reset request, status/mask interrupt and register port.
  Assumes a CPU-side decoder pulses the service, enable and disable
  inputs for one cycle, and a system reset block acts on reset_request.
*/
// Summary of operation
// - After every reset the watchdog counts without any software action.
// - Disable and enable instructions stop or restart the counter at once.
// - Software services before overflow; an overflow raises a reset request.
// - A service inside the forbidden window phase raises a reset request.
// - Counter is 16-bit, counting up, from system or wake-up clock.
// - Selected clock is divided by 256 or 16384 before advancing the counter.
// - Every valid service reloads the counter from the reload register.
// - Default reload and ratio give about 0.13 s at a 500 kHz wake-up clock.
`timescale 1ns/1ps
module wwdt_top #(
  parameter int CNT_W = 16,
  parameter int DIV_A = wwdt_pkg::DIV_LO,
  parameter int DIV_B = wwdt_pkg::DIV_HI
) (
  input wire logic clk, // system clock, 20 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic wakeup_osc_clock, // independent wake-up clock
  input wire logic watchdog_service, // service pulse from software
  input wire logic watchdog_disable_instr, // disable instruction pulse
  input wire logic watchdog_enable_instr, // enable instruction pulse
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [31:0] rd_data, // read data, cycle after rd_en
  output logic reset_request, // one-cycle reset request
  output logic irq // level interrupt
);
  initial begin
    if (CNT_W != 16) begin
      $error("wwdt_top: counter width must be 16");
    end
  end

  // ==========================================================
  // state
  logic enabled;
  logic clk_sel;
  logic div_sel;
  logic [15:0] watchdog_reload_value;
  logic [15:0] window_bound;
  logic [15:0] count;
  logic [wwdt_pkg::EVT_W-1:0] status;
  logic [wwdt_pkg::EVT_W-1:0] mask;

  logic next_enabled;
  logic next_clk_sel;
  logic next_div_sel;
  logic [15:0] next_reload;
  logic [15:0] next_window;
  logic [15:0] next_count;
  logic [wwdt_pkg::EVT_W-1:0] next_status;
  logic [wwdt_pkg::EVT_W-1:0] next_mask;
  logic [31:0] next_rd_data;
  logic next_reset_request;
  logic next_irq;

  logic wu_rise;
  logic src_pulse;
  logic tick;
  logic overflow;
  logic win_fault;
  logic good_service;
  logic presc_clear;
  logic [wwdt_pkg::EVT_W-1:0] events;
  logic [wwdt_pkg::EVT_W-1:0] w1c;

  // ==========================================================
  // clock source and prescaler
  wwdt_edge_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(wakeup_osc_clock),
    .rise(wu_rise)
  );

  // system clock source counts every cycle
  assign src_pulse = enabled & (clk_sel ? wu_rise : 1'b1);
  // restart division so a fresh interval is whole
  assign presc_clear = good_service | watchdog_enable_instr | ~enabled;

  wwdt_prescaler #(
    .DIV_A(DIV_A),
    .DIV_B(DIV_B)
  ) u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .clear(presc_clear),
    .src_pulse(src_pulse),
    .div_sel(div_sel),
    .tick(tick)
  );

  // ==========================================================
  // service judgement and counter
  always_comb begin
    // service below the boundary is still in the forbidden phase
    win_fault = enabled & watchdog_service & (count < window_bound);
    good_service = watchdog_service & ~win_fault;
    overflow = enabled & tick & (count == 16'hFFFF) & ~watchdog_service;

    next_enabled = enabled;
    if (watchdog_disable_instr) begin
      next_enabled = 1'b0;
    end else if (watchdog_enable_instr) begin
      next_enabled = 1'b1;
    end

    next_count = count;
    if (good_service || win_fault || overflow) begin
      // a fault also reloads so the next interval starts clean
      next_count = watchdog_reload_value;
    end else if (enabled && tick) begin
      next_count = count + 16'h0001;
    end

    next_reset_request = overflow | win_fault;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enabled <= 1'b1;
      count <= wwdt_pkg::RELOAD_RST;
      reset_request <= 1'b0;
    end else begin
      enabled <= next_enabled;
      count <= next_count;
      reset_request <= next_reset_request;
    end
  end

  // ==========================================================
  // register port
  always_comb begin
    next_clk_sel = clk_sel;
    next_div_sel = div_sel;
    next_reload = watchdog_reload_value;
    next_window = window_bound;
    next_mask = mask;
    w1c = '0;
    if (wr_en) begin
      if (addr == wwdt_pkg::ADDR_CTRL) begin
        next_clk_sel = wr_data[wwdt_pkg::CTRL_CLKSEL_BIT];
        next_div_sel = wr_data[wwdt_pkg::CTRL_DIVSEL_BIT];
      end else if (addr == wwdt_pkg::ADDR_RELOAD) begin
        next_reload = wr_data[15:0];
      end else if (addr == wwdt_pkg::ADDR_WINDOW) begin
        next_window = wr_data[15:0];
      end else if (addr == wwdt_pkg::ADDR_STATUS) begin
        w1c = wr_data[wwdt_pkg::EVT_W-1:0];
      end else if (addr == wwdt_pkg::ADDR_MASK) begin
        next_mask = wr_data[wwdt_pkg::EVT_W-1:0];
      end
    end

    next_rd_data = 32'h0000_0000;
    if (rd_en) begin
      if (addr == wwdt_pkg::ADDR_CTRL) begin
        next_rd_data[wwdt_pkg::CTRL_EN_BIT] = enabled;
        next_rd_data[wwdt_pkg::CTRL_CLKSEL_BIT] = clk_sel;
        next_rd_data[wwdt_pkg::CTRL_DIVSEL_BIT] = div_sel;
      end else if (addr == wwdt_pkg::ADDR_RELOAD) begin
        next_rd_data[15:0] = watchdog_reload_value;
      end else if (addr == wwdt_pkg::ADDR_WINDOW) begin
        next_rd_data[15:0] = window_bound;
      end else if (addr == wwdt_pkg::ADDR_COUNT) begin
        next_rd_data[15:0] = count;
      end else if (addr == wwdt_pkg::ADDR_STATUS) begin
        next_rd_data[wwdt_pkg::EVT_W-1:0] = status;
      end else if (addr == wwdt_pkg::ADDR_MASK) begin
        next_rd_data[wwdt_pkg::EVT_W-1:0] = mask;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel <= wwdt_pkg::CLKSEL_RST;
      div_sel <= wwdt_pkg::DIVSEL_RST;
      watchdog_reload_value <= wwdt_pkg::RELOAD_RST;
      window_bound <= wwdt_pkg::WINDOW_RST;
      mask <= wwdt_pkg::MASK_RST;
      rd_data <= 32'h0000_0000;
    end else begin
      clk_sel <= next_clk_sel;
      div_sel <= next_div_sel;
      watchdog_reload_value <= next_reload;
      window_bound <= next_window;
      mask <= next_mask;
      rd_data <= next_rd_data;
    end
  end

  // ==========================================================
  // sticky status and interrupt
  always_comb begin
    events = '0;
    events[wwdt_pkg::STAT_OVF_BIT] = overflow;
    events[wwdt_pkg::STAT_WIN_BIT] = win_fault;
    // a new event wins over a clear in the same cycle
    next_status = (status & ~w1c) | events;
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= next_irq;
    end
  end
endmodule

// ===== testbench/wwdt_checker.sv
/* port checker of the window watchdog.
   assumes a bind from the bench top, one clock domain. */
`timescale 1ns/1ps
module wwdt_checker (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic watchdog_service, // service pulse
  input wire logic watchdog_disable_instr, // disable pulse
  input wire logic watchdog_enable_instr, // enable pulse
  input wire logic [7:0] addr, // register address
  input wire logic [31:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  input wire logic [31:0] rd_data, // read data
  input wire logic reset_request, // reset request pulse
  input wire logic irq // level interrupt
);
  // ==========================================================
  // shadow of software-visible state
  logic en_m;
  logic [15:0] win_m;
  logic [1:0] mask_m;
  logic [15:0] rel_m;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_m <= 1'b1;
      win_m <= 16'h0000;
      mask_m <= 2'h0;
      rel_m <= wwdt_pkg::RELOAD_RST;
    end else begin
      // disable wins when both pulse together
      if (watchdog_disable_instr) en_m <= 1'b0;
      else if (watchdog_enable_instr) en_m <= 1'b1;
      if (wr_en && addr == wwdt_pkg::ADDR_WINDOW) win_m <= wr_data[15:0];
      if (wr_en && addr == wwdt_pkg::ADDR_MASK) mask_m <= wr_data[1:0];
      if (wr_en && addr == wwdt_pkg::ADDR_RELOAD) rel_m <= wr_data[15:0];
    end
  end
  // ==========================================================
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 32'h0000_0000)
    else $error("read data not zero outside read slot");
  win_read_a: assert property (rd_en && !wr_en && addr == wwdt_pkg::ADDR_WINDOW
    |=> rd_data == {16'h0000, $past(win_m)}) else $error("window readback wrong");
  // any service reloads; two cycles later the count is at most one tick past reload
  win_fault_a: assert property (watchdog_service && !wr_en ##1 !wr_en ##1
    watchdog_service && en_m && (17'(rel_m) + 17'h0_0001 < 17'(win_m))
    |=> reset_request) else $error("service in window gave no reset request");
  win_ok_a: assert property (watchdog_service && en_m && win_m == 16'h0000
    |=> !reset_request) else $error("service outside window gave reset request");
  off_quiet_a: assert property (!$past(en_m) |-> !reset_request)
    else $error("reset request while disabled");
  irq_mask_a: assert property (mask_m == 2'h0 |-> !irq)
    else $error("interrupt with all events masked");
  irq_raise_a: assert property (reset_request && mask_m == 2'h3 |-> ##[0:1] irq)
    else $error("interrupt missing after event");
  en_read_a: assert property (rd_en && addr == wwdt_pkg::ADDR_CTRL
    |=> rd_data[0] == $past(en_m)) else $error("enable bit readback wrong");
  cnt_wide_a: assert property (rd_en && addr == wwdt_pkg::ADDR_COUNT
    |=> rd_data[31:16] == 16'h0000) else $error("count upper bits not zero");
  win_cov: cover property (watchdog_service && en_m && win_m != 16'h0000 ##1 reset_request);
  irq_cov: cover property (reset_request ##1 irq);
  off_cov: cover property (watchdog_disable_instr ##1 !en_m);
endmodule

// ===== testbench/wwdt_partner.sv
/* system reset logic and wake-up oscillator beside the watchdog.
   assumes reset_request is a one-cycle pulse on clk. */
`timescale 1ns/1ps
module wwdt_partner (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic reset_request, // request from watchdog
  output logic wakeup_osc_clock, // free-running 500 kHz
  output int req_count // requests latched so far
);
  initial wakeup_osc_clock = 1'b0;
  // oscillator runs free, its edges always on falling edges of clk
  always #1000 wakeup_osc_clock = ~wakeup_osc_clock;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) req_count <= 0;
    else if (reset_request) req_count <= req_count + 1;
  end
endmodule

// ===== testbench/window_watchdog_timer_bench.sv
/* self-checking bench of the window watchdog.
   assumes prescaler ratios shortened to 4 and 8. */
`timescale 1ns/1ps
module window_watchdog_timer_bench;
  logic clk = 1'b0;
  logic rst_n;
  logic [2:0] ins;
  logic [7:0] addr;
  logic [31:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic rd_v = 1'b0;
  logic [31:0] rd_data;
  logic reset_request;
  logic irq;
  logic wk;
  int req_count;
  int err_total = 0;
  int comparisons = 0;
  int n;
  int cyc;
  logic [31:0] expq[$];
  always #25 clk = ~clk;
  wwdt_top #(.DIV_A(4), .DIV_B(8)) u_dut (.clk(clk), .rst_n(rst_n),
    .wakeup_osc_clock(wk), .watchdog_service(ins[0]), .watchdog_disable_instr(ins[1]),
    .watchdog_enable_instr(ins[2]), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .reset_request(reset_request), .irq(irq));
  wwdt_partner u_part (.clk(clk), .rst_n(rst_n), .reset_request(reset_request),
    .wakeup_osc_clock(wk), .req_count(req_count));
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    ins <= 3'(1 << k);
    @(posedge clk);
    ins <= 3'h0;
  endtask
  task automatic wait_req();
    n = req_count;
    cyc = 0;
    while (req_count == n && cyc < 4000) begin
      @(posedge clk);
      cyc++;
    end
    if (cyc >= 4000) begin
      err_total++;
      end_sim();
    end
  endtask
  // service, then time the interval up to the overflow request
  task automatic span(input logic [15:0] r, input int per);
    int e;
    e = (32'h0001_0000 - r) * per;
    wr(wwdt_pkg::ADDR_RELOAD, {16'h0000, r});
    pulse(0);
    wait_req();
    chk("interval", 32'(cyc >= e - per / 4 - 9 && cyc <= e + per / 4 + 9), 1);
  endtask
  // read data stand in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_v) chk("rd_data", rd_data, expq.pop_front());
    rd_v <= rd_en;
  end
  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    {ins, addr, wr_data, wr_en, rd_en} = '0;
    void'($urandom(78016));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(wwdt_pkg::ADDR_CTRL, 32'h0000_0003);
    rd(wwdt_pkg::ADDR_RELOAD, 32'h0000_FF03);
    rd(wwdt_pkg::ADDR_WINDOW, 32'h0000_0000);
    rd(wwdt_pkg::ADDR_STATUS, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    $display("reset values done");
    wr(wwdt_pkg::ADDR_CTRL, 32'h0000_0000);
    rd(wwdt_pkg::ADDR_CTRL, 32'h0000_0001);
    for (int i = 0; i < 3; i++) span(16'hFFFF - 16'($urandom % 24), 4);
    wr(wwdt_pkg::ADDR_CTRL, 32'h0000_0004);
    span(16'hFFF0, 8);
    wr(wwdt_pkg::ADDR_CTRL, 32'h0000_0002);
    span(16'hFFF8, 160);
    $display("intervals done");
    wr(wwdt_pkg::ADDR_CTRL, 32'h0000_0000);
    wr(wwdt_pkg::ADDR_RELOAD, 32'h0000_FFF0);
    pulse(0);
    n = req_count;
    repeat (5) begin
      repeat (40) @(posedge clk);
      pulse(0);
    end
    chk("kept_alive", 32'(req_count), 32'(n));
    pulse(1);
    repeat (200) @(posedge clk);
    chk("disabled", 32'(req_count), 32'(n));
    pulse(0);
    rd(wwdt_pkg::ADDR_COUNT, 32'h0000_FFF0);
    rd(wwdt_pkg::ADDR_CTRL, 32'h0000_0000);
    pulse(2);
    rd(wwdt_pkg::ADDR_CTRL, 32'h0000_0001);
    wait_req();
    $display("enable control done");
    wr(wwdt_pkg::ADDR_WINDOW, 32'h0000_FFF8);
    pulse(0);
    repeat (3) @(posedge clk);
    n = req_count;
    pulse(0);
    repeat (2) @(posedge clk);
    chk("window_fault", 32'(req_count), 32'(n + 1));
    repeat (40) @(posedge clk);
    n = req_count;
    pulse(0);
    repeat (2) @(posedge clk);
    chk("window_open", 32'(req_count), 32'(n));
    n = req_count;
    pulse(0);
    pulse(0);
    repeat (3) @(posedge clk);
    chk("window_back", 32'(req_count), 32'(n + 2));
    rd(wwdt_pkg::ADDR_STATUS, 32'h0000_0003);
    wr(wwdt_pkg::ADDR_STATUS, 32'h0000_0003);
    rd(wwdt_pkg::ADDR_STATUS, 32'h0000_0000);
    $display("window done");
    wr(wwdt_pkg::ADDR_WINDOW, 32'h0000_0000);
    wr(wwdt_pkg::ADDR_MASK, 32'h0000_0003);
    wait_req();
    repeat (2) @(posedge clk);
    chk("irq_set", 32'(irq), 1);
    wr(wwdt_pkg::ADDR_STATUS, 32'h0000_0001);
    @(posedge clk);
    chk("irq_clear", 32'(irq), 0);
    rd(wwdt_pkg::ADDR_MASK, 32'h0000_0003);
    $display("interrupt done");
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule
bind wwdt_top wwdt_checker u_chk (.clk(clk), .rst_n(rst_n),
  .watchdog_service(watchdog_service), .watchdog_disable_instr(watchdog_disable_instr),
  .watchdog_enable_instr(watchdog_enable_instr), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .reset_request(reset_request), .irq(irq));
